/* File: src/timer16_ctrl.sv */
/*
 16-bit free-running timer with two captures, two compares, single pulse and
 pwm modes, prescaler or external clock, halt freeze and one interrupt.
 assumes a classic wishbone master on clk_i, pins asynchronous to clk_i.
*/
// Chosen here: the register addresses and the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
module timer16_ctrl #(
   parameter bit has_ext_clk = 1'b1
) (
   // system
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // power and cpu
   input wire logic halt_i,
   input wire logic global_mask_i,
   output logic irq_o,
   output logic wake_o,
   // pins
   input wire logic capture_in_one_i,
   input wire logic capture_in_two_i,
   input wire logic ext_timer_clock_pin_i,
   output timer16_pkg::pins_t pins_o
);
   import timer16_pkg::*;

   state_t s_r;
   state_t s_nxt;
   mode_t mode;
   logic [7:0] c1;
   logic [7:0] c2;
   logic tick;
   logic ext_edge;
   logic [1:0] cap_edge;
   logic [1:0] cap_fire;
   logic m1;
   logic m2;
   logic req;
   logic wr;
   logic rd;
   logic [4:0] ev;
   logic [4:0] fset;

   assign c1 = s_r.ctrl_one;
   assign c2 = s_r.ctrl_two;

   // pwm wins over single pulse
   always_comb begin
      if (c2[pwm_mode_b])
         mode = mode_pwm;
      else if (c2[single_pulse_mode_b])
         mode = mode_pulse;
      else
         mode = mode_free;
   end

   // edge detection after the two-stage synchronisers
   assign ext_edge = c2[ext_clk_edge_sel_b] ? (s_r.ext_sync2 & ~s_r.ext_last)
                     : (~s_r.ext_sync2 & s_r.ext_last);
   assign cap_edge[0] = c1[cap_one_edge_sel_b] ? (s_r.cap_sync2[0] & ~s_r.cap_last[0])
                        : (~s_r.cap_sync2[0] & s_r.cap_last[0]);
   assign cap_edge[1] = c2[cap_two_edge_sel_b] ? (s_r.cap_sync2[1] & ~s_r.cap_last[1])
                        : (~s_r.cap_sync2[1] & s_r.cap_last[1]);

   // timer tick from prescaler or external pin
   always_comb begin
      case (c2[clock_select_hi_b:clock_select_lo_b])
         clk_div4: tick = (s_r.presc & div4_mask) == div4_mask;
         clk_div2: tick = (s_r.presc & div2_mask) == div2_mask;
         clk_div8: tick = (s_r.presc & div8_mask) == div8_mask;
         clk_ext: tick = has_ext_clk & ext_edge;
         default: tick = 1'b0;
      endcase
   end

   assign m1 = s_r.count == s_r.cmp_one;
   assign m2 = s_r.count == s_r.cmp_two;

   // capture inputs: pin one is owned by pulse/pwm modes
   assign cap_fire[0] = cap_edge[0] & (mode == mode_free);
   assign cap_fire[1] = cap_edge[1];

   // bus decode: single-cycle answer, ack drops after one cycle
   assign req = cyc_i & stb_i & ~s_r.ack;
   // a write lands on the edge where the master sees ack high
   assign wr = cyc_i & stb_i & s_r.ack & we_i & sel_i[0];
   assign rd = req & ~we_i;

   // interrupt and wake request
   assign ev = s_r.flags & {c1[capture_irq_enable_b], c1[compare_irq_enable_b],
                            c1[overflow_irq_enable_b], c1[capture_irq_enable_b],
                            c1[compare_irq_enable_b]};
   assign irq_o = (|ev) & ~global_mask_i;
   assign wake_o = irq_o;

   assign dat_o = s_r.rdata;
   assign ack_o = s_r.ack;
   assign pins_o.out_one = s_r.out_one;
   assign pins_o.out_two = s_r.out_two;
   assign pins_o.out_one_oe = c2[cmp_one_pin_en_b];
   assign pins_o.out_two_oe = c2[cmp_two_pin_en_b];

   // next-state logic for the whole block
   always_comb begin
      s_nxt = s_r;
      // collect only this cycle's hardware flag events here
      s_nxt.flags = 5'h0;
      s_nxt.ack = req;
      // synchronisers always run
      s_nxt.cap_sync1 = {capture_in_two_i, capture_in_one_i};
      s_nxt.cap_sync2 = s_r.cap_sync1;
      s_nxt.cap_last = s_r.cap_sync2;
      s_nxt.ext_sync1 = ext_timer_clock_pin_i;
      s_nxt.ext_sync2 = s_r.ext_sync1;
      s_nxt.ext_last = s_r.ext_sync2;
      s_nxt.halted = halt_i;
      if (halt_i) begin
         // frozen; remember selected capture edges
         if (cap_fire[0])
            s_nxt.armed[0] = 1'b1;
         if (cap_fire[1])
            s_nxt.armed[1] = 1'b1;
      end else begin
         // counter and prescaler, wait mode runs unchanged
         s_nxt.presc = s_r.presc + 3'h1;
         if (tick) begin
            s_nxt.count = s_r.count + 16'h0001;
            if (s_r.count == 16'hffff)
               s_nxt.flags[overflow_flag_b - 3] = 1'b1;
         end
         // halt exit: armed captures take the held count
         if (s_r.halted) begin
            if (s_r.armed[0]) begin
               s_nxt.flags[cap_one_flag_b - 3] = 1'b1;
               s_nxt.cap_one = s_r.count;
            end
            if (s_r.armed[1]) begin
               s_nxt.flags[cap_two_flag_b - 3] = 1'b1;
               s_nxt.cap_two = s_r.count;
            end
            s_nxt.armed = 2'h0;
         end
         // normal captures
         if (cap_fire[0]) begin
            s_nxt.flags[cap_one_flag_b - 3] = 1'b1;
            s_nxt.cap_one = s_r.count;
         end
         if (cap_fire[1]) begin
            s_nxt.flags[cap_two_flag_b - 3] = 1'b1;
            s_nxt.cap_two = s_r.count;
         end
         // compare and waveform logic per mode
         case (mode)
            mode_pwm: begin
               if (m1)
                  s_nxt.out_one = c1[out_level_one_b];
               if (m2) begin
                  s_nxt.out_one = c1[out_level_two_b];
                  s_nxt.count = count_reset;
                  s_nxt.flags[cap_one_flag_b - 3] = 1'b1;
               end
            end
            mode_pulse: begin
               if (cap_edge[0]) begin
                  s_nxt.count = count_reset;
                  s_nxt.out_one = c1[out_level_two_b];
                  s_nxt.flags[cap_one_flag_b - 3] = 1'b1;
                  s_nxt.cap_one = count_reset + 16'h0001;
               end else if (m1) begin
                  s_nxt.out_one = c1[out_level_one_b];
               end
               if (m2)
                  s_nxt.flags[cmp_two_flag_b - 3] = 1'b1;
            end
            default: begin
               if (m1) begin
                  s_nxt.flags[cmp_one_flag_b - 3] = 1'b1;
                  s_nxt.out_one = c1[out_level_one_b];
               end
               if (m2) begin
                  s_nxt.flags[cmp_two_flag_b - 3] = 1'b1;
                  s_nxt.out_two = c1[out_level_two_b];
               end
               if (c1[force_out_one_b])
                  s_nxt.out_one = c1[out_level_one_b];
               if (c1[force_out_two_b])
                  s_nxt.out_two = c1[out_level_two_b];
            end
         endcase
      end
      // register writes; hardware set wins over write-one-to-clear
      fset = s_nxt.flags;
      s_nxt.flags = s_r.flags | fset;
      if (wr) begin
         case (adr_i)
            ctrl_one_off: s_nxt.ctrl_one = dat_i[7:0];
            ctrl_two_off: s_nxt.ctrl_two = dat_i[7:0];
            status_off: s_nxt.flags = (s_r.flags & ~dat_i[7:3]) | fset;
            cmp_one_off: s_nxt.cmp_one = dat_i[15:0];
            cmp_two_off: s_nxt.cmp_two = dat_i[15:0];
            count_off: s_nxt.count = count_reset;
            default: ;
         endcase
      end
      // read mux
      s_nxt.rdata = 32'h0;
      if (rd) begin
         case (adr_i)
            ctrl_one_off: s_nxt.rdata = {24'h0, c1};
            ctrl_two_off: s_nxt.rdata = {24'h0, c2};
            status_off: s_nxt.rdata = {24'h0, s_r.flags, 3'h0};
            cap_one_off: s_nxt.rdata = {16'h0, s_r.cap_one};
            cap_two_off: s_nxt.rdata = {16'h0, s_r.cap_two};
            cmp_one_off: s_nxt.rdata = {16'h0, s_r.cmp_one};
            cmp_two_off: s_nxt.rdata = {16'h0, s_r.cmp_two};
            count_off: s_nxt.rdata = {16'h0, s_r.count};
            default: s_nxt.rdata = 32'h0;
         endcase
      end
   end

   // state register with synchronous reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r <= '0;
         s_r.ctrl_one <= ctrl_reset;
         s_r.ctrl_two <= ctrl_reset;
         s_r.count <= count_reset;
         s_r.cmp_one <= cmp_reset;
         s_r.cmp_two <= cmp_reset;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule
`default_nettype wire

/* File: src/timer16_pkg.sv */
/*
 package for the 16-bit timer control block: register offsets, control field
 positions, reset values, modes and the packed state carrier.
 assumes a 32-bit classic wishbone slave port with word-aligned registers.
*/
package timer16_pkg;
   // register byte offsets
   localparam logic [7:0] ctrl_two_off = 8'h00;
   localparam logic [7:0] ctrl_one_off = 8'h04;
   localparam logic [7:0] status_off = 8'h08;
   localparam logic [7:0] cap_one_off = 8'h0c;
   localparam logic [7:0] cap_two_off = 8'h10;
   localparam logic [7:0] cmp_one_off = 8'h14;
   localparam logic [7:0] cmp_two_off = 8'h18;
   localparam logic [7:0] count_off = 8'h1c;
   // control one fields
   localparam int capture_irq_enable_b = 7;
   localparam int compare_irq_enable_b = 6;
   localparam int overflow_irq_enable_b = 5;
   localparam int force_out_two_b = 4;
   localparam int force_out_one_b = 3;
   localparam int out_level_two_b = 2;
   localparam int cap_one_edge_sel_b = 1;
   localparam int out_level_one_b = 0;
   // control two fields
   localparam int cmp_one_pin_en_b = 7;
   localparam int cmp_two_pin_en_b = 6;
   localparam int single_pulse_mode_b = 5;
   localparam int pwm_mode_b = 4;
   localparam int clock_select_hi_b = 3;
   localparam int clock_select_lo_b = 2;
   localparam int cap_two_edge_sel_b = 1;
   localparam int ext_clk_edge_sel_b = 0;
   // status fields (write one to clear)
   localparam int cap_one_flag_b = 7;
   localparam int cmp_one_flag_b = 6;
   localparam int overflow_flag_b = 5;
   localparam int cap_two_flag_b = 4;
   localparam int cmp_two_flag_b = 3;
   // reset values and clock choices
   localparam logic [7:0] ctrl_reset = 8'h00;
   localparam logic [15:0] count_reset = 16'hfffc;
   localparam logic [15:0] cmp_reset = 16'h8000;
   localparam logic [1:0] clk_div4 = 2'h0;
   localparam logic [1:0] clk_div2 = 2'h1;
   localparam logic [1:0] clk_div8 = 2'h2;
   localparam logic [1:0] clk_ext = 2'h3;
   localparam logic [2:0] div2_mask = 3'h1;
   localparam logic [2:0] div4_mask = 3'h3;
   localparam logic [2:0] div8_mask = 3'h7;

   typedef enum logic [1:0] {mode_free, mode_pulse, mode_pwm} mode_t;

   typedef struct packed {
      logic [7:0] ctrl_one;
      logic [7:0] ctrl_two;
      logic [4:0] flags;   // cap1, cmp1, ovf, cap2, cmp2
      logic [15:0] count;
      logic [15:0] cap_one;
      logic [15:0] cap_two;
      logic [15:0] cmp_one;
      logic [15:0] cmp_two;
      logic [2:0] presc;
      logic [1:0] cap_sync1;
      logic [1:0] cap_sync2;
      logic [1:0] cap_last;
      logic ext_sync1;
      logic ext_sync2;
      logic ext_last;
      logic [1:0] armed;
      logic halted;
      logic out_one;
      logic out_two;
      logic ack;
      logic [31:0] rdata;
   } state_t;

   typedef struct packed {
      logic out_one;
      logic out_one_oe;
      logic out_two;
      logic out_two_oe;
   } pins_t;
endpackage

/* File: verification/timer16_checker.sv */
/*
 port checker for the timer: bus answer, interrupt gating and pin outputs.
 assumes it is bound to timer16_ctrl and runs on its clock.
*/
`timescale 1ns/100ps
`default_nettype none
module timer16_checker (
   // system
   input wire logic clk_i,
   input wire logic rst_i,
   // bus
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic ack_o,
   // cpu and pins
   input wire logic global_mask_i,
   input wire logic irq_o,
   input wire logic wake_o,
   input wire timer16_pkg::pins_t pins_o
);
   import timer16_pkg::*;
   logic [7:0] c1_r;
   logic [7:0] c2_r;
   // shadow copies of the control registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         c1_r <= ctrl_reset;
         c2_r <= ctrl_reset;
      end else if (cyc_i && stb_i && we_i && sel_i[0] && ack_o) begin
         if (adr_i == ctrl_one_off) c1_r <= dat_i[7:0];
         if (adr_i == ctrl_two_off) c2_r <= dat_i[7:0];
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // bus answer and interrupt gating
   a_ack_single:
      assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
   a_ack_answer:
      assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("request not answered");
   a_irq_mask:
      assert property (global_mask_i |-> !irq_o) else $error("irq while masked");
   a_wake_irq:
      assert property (wake_o == irq_o) else $error("wake differs from irq");
   a_irq_enable:
      assert property (irq_o |-> |c1_r[7:5]) else $error("irq without enable");
   // pin enables and forced levels
   a_oe_one:
      assert property ($stable(c2_r) |-> pins_o.out_one_oe == c2_r[7]) else $error("pin one enable");
   a_oe_two:
      assert property ($stable(c2_r) |-> pins_o.out_two_oe == c2_r[6]) else $error("pin two enable");
   a_force_one:
      assert property ($stable({c1_r, c2_r}) && c1_r[3] && c2_r[7] && c2_r[5:4] == 2'h0
         |-> pins_o.out_one == c1_r[0]) else $error("forced level one");
   a_force_two:
      assert property ($stable({c1_r, c2_r}) && c1_r[4] && c2_r[6] && c2_r[5:4] == 2'h0
         |-> pins_o.out_two == c1_r[2]) else $error("forced level two");
   cover property (irq_o);
   cover property (pins_o.out_two_oe && pins_o.out_two);
   cover property (ack_o && we_i);
endmodule
bind timer16_ctrl timer16_checker timer16_checker_inst (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
   .adr_i, .sel_i, .dat_i, .ack_o, .global_mask_i, .irq_o, .wake_o, .pins_o);
`default_nettype wire

/* File: verification/timer16_pins.sv */
/*
 pin model: capture inputs and external clock.
 assumes its tasks are called just after a rising edge of clk_i.
*/
`timescale 1ns/100ps
`default_nettype none
module timer16_pins (
   // clock
   input wire logic clk_i,
   // pins toward the timer
   output var logic cap_one_o,
   output var logic cap_two_o,
   output var logic ext_o
);
   // idle: inputs low, external clock stopped low
   initial begin
      cap_one_o = 1'b0;
      cap_two_o = 1'b0;
      ext_o = 1'b0;
   end
   // move one capture pin and hold past the synchroniser
   task automatic set_cap(input bit two, input logic v);
      if (two) cap_two_o <= v;
      else cap_one_o <= v;
      repeat (6) @(posedge clk_i);
   endtask
   // n external clock periods, still outside the burst
   task automatic ext_burst(input int n);
      repeat (n) begin
         ext_o <= 1'b1;
         repeat (4) @(posedge clk_i);
         ext_o <= 1'b0;
         repeat (4) @(posedge clk_i);
      end
   endtask
endmodule
`default_nettype wire

/* File: verification/tb.sv */
/*
 bench for timer16_ctrl: registers, clock choices, halt, irq, pins, captures.
 assumes the pin model and checker are compiled before it.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
   import timer16_pkg::*;
   logic clk_i, rst_i, cyc_i, stb_i, we_i, halt_i, global_mask_i, ack_o, irq_o, wake_o, c1, c2, ex;
   logic [7:0] adr_i;
   logic [3:0] sel_i;
   logic [31:0] dat_i, dat_o, q;
   logic [15:0] c0;
   logic [15:0] adv [4] = '{16'h10, 16'h20, 16'h8, 16'h5};
   pins_t pins_o;
   int err_total, n_checks;
   timer16_ctrl timer16_ctrl_inst (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
      .dat_o, .ack_o, .halt_i, .global_mask_i, .irq_o, .wake_o, .capture_in_one_i(c1),
      .capture_in_two_i(c2), .ext_timer_clock_pin_i(ex), .pins_o);
   timer16_pins timer16_pins_inst (.clk_i, .cap_one_o(c1), .cap_two_o(c2), .ext_o(ex));
   always #5 clk_i = ~clk_i;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one classic bus cycle, released after ack
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      logic got;
      n = 0;
      got = 1'b0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      // ack and data are read while settled, then the edge that samples them passes
      while (got !== 1'b1 && n < 50) begin
         @(negedge clk_i);
         got = ack_o;
         q = dat_o;
         @(posedge clk_i);
         n++;
      end
      if (got !== 1'b1) err_total++;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0);
      chk(q, exp);
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // watchdog
   initial begin
      repeat (20000) @(posedge clk_i);
      err_total++;
      stop_test();
   end
   initial begin
      {clk_i, rst_i, cyc_i, stb_i, we_i, global_mask_i, halt_i} = 7'h23;
      adr_i = 8'h0;
      sel_i = 4'hf;
      dat_i = 32'h0;
      err_total = 0;
      n_checks = 0;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(ctrl_one_off, 32'h0);
      rd(ctrl_two_off, 32'h0);
      rd(count_off, {16'h0, count_reset});
      wb(1'b1, 8'h20, 32'h5a);
      rd(8'h20, 32'h0);
      wb(1'b1, ctrl_one_off, 32'h1a);
      rd(ctrl_one_off, 32'h1a);
      $display("test registers done");
      // advance over 64 cycles out of halt for each clock choice
      for (int k = 0; k < 4; k++) begin
         wb(1'b1, ctrl_two_off, {28'h0, k[1:0], 2'h1});
         wb(1'b0, count_off, 32'h0);
         c0 = q[15:0];
         halt_i <= 1'b0;
         timer16_pins_inst.ext_burst(k == 3 ? 5 : 0);
         repeat (k == 3 ? 24 : 64) @(posedge clk_i);
         halt_i <= 1'b1;
         @(posedge clk_i);
         rd(count_off, {16'h0, c0 + adv[k]});
      end
      c0 = q[15:0];
      repeat (20) @(posedge clk_i);
      rd(count_off, {16'h0, c0});
      rd(status_off, 32'h20);
      global_mask_i <= 1'b1;
      wb(1'b1, ctrl_one_off, 32'h20);
      chk(irq_o, 1'b0);
      global_mask_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk({wake_o, irq_o}, 2'h3);
      wb(1'b1, ctrl_one_off, 32'h0);
      chk(irq_o, 1'b0);
      $display("test counter done");
      halt_i <= 1'b0;
      wb(1'b1, ctrl_two_off, 32'hc0);
      wb(1'b1, ctrl_one_off, 32'h1d);
      @(posedge clk_i);
      chk(pins_o, 4'hf);
      wb(1'b1, ctrl_one_off, 32'h18);
      @(posedge clk_i);
      chk(pins_o, 4'h5);
      wb(1'b1, ctrl_two_off, 32'h0);
      chk({pins_o.out_one_oe, pins_o.out_two_oe}, 2'h0);
      $display("test pins done");
      wb(1'b1, ctrl_one_off, 32'h82);
      timer16_pins_inst.set_cap(1'b0, 1'b1);
      chk(irq_o, 1'b1);
      rd(status_off, 32'ha0);
      wb(1'b1, status_off, 32'h80);
      timer16_pins_inst.set_cap(1'b0, 1'b0);
      rd(status_off, 32'h20);
      timer16_pins_inst.set_cap(1'b1, 1'b1);
      timer16_pins_inst.set_cap(1'b1, 1'b0);
      rd(status_off, 32'h30);
      wb(1'b1, ctrl_one_off, 32'h02);
      chk(irq_o, 1'b0);
      // falling edge on capture two while halted
      wb(1'b1, status_off, 32'h10);
      halt_i <= 1'b1;
      wb(1'b0, count_off, 32'h0);
      c0 = q[15:0];
      timer16_pins_inst.set_cap(1'b1, 1'b1);
      timer16_pins_inst.set_cap(1'b1, 1'b0);
      halt_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      rd(cap_two_off, {16'h0, c0});
      rd(status_off, 32'h30);
      $display("test captures done");
      // compare matches in free mode at counts 2 and 3 after a counter restart
      wb(1'b1, ctrl_two_off, 32'hc0);
      wb(1'b1, ctrl_one_off, 32'h05);
      wb(1'b1, cmp_one_off, 32'h0002);
      wb(1'b1, cmp_two_off, 32'h0003);
      wb(1'b1, status_off, 32'hf8);
      wb(1'b1, count_off, 32'h0);
      repeat (40) @(posedge clk_i);
      chk(pins_o, 4'hf);
      rd(status_off, 32'h68);
      // pwm: period end at compare two restarts count, flags capture one only
      wb(1'b1, status_off, 32'hf8);
      wb(1'b1, ctrl_two_off, 32'h90);
      wb(1'b1, count_off, 32'h0);
      repeat (40) @(posedge clk_i);
      rd(status_off, 32'ha0);
      $display("test compares done");
      stop_test();
   end
endmodule
`default_nettype wire
